/* mbf_map.vh */
`ifndef MBF_MAP_VH
`define MBF_MAP_VH
`define MBF_REG_CTRL 4'h0
`define MBF_REG_STAT 4'h1
`define MBF_REG_NODE 4'h2
`define MBF_REG_BAUD 4'h3
`define MBF_REG_RXB 4'h4
`define MBF_REG_TXB 4'h5
`define MBF_REG_TXV 4'h6
`define MBF_REG_TYPE 4'h7
`define MBF_REG_PASS 4'h8
`define MBF_REG_LIST 4'h9
`define MBF_REG_SIZE 4'ha
`define MBF_CTRL_REL 8
`define MBF_TXB_LAST 8
`define MBF_MODE_OFF 2'h0
`define MBF_MODE_WORD 2'h1
`define MBF_MODE_TYPED 2'h2
`define MBF_TYPE_SHORT 2'h0
`define MBF_NODE_RST 8'h01
`define MBF_NODE_MAX 8'hfa
`define MBF_CLK_HZ 200000000
`define MBF_BAUD_MIN 9600
`define MBF_BAUD_MAX 115200
`define MBF_GAP_BITS 6'h23
`define MBF_PASS_USER 16'h0c46
`define MBF_LIST_BASE 17'h09c41
`define MBF_FC_READ 8'h03
`define MBF_FC_WR1 8'h06
`define MBF_FC_WRN 8'h10
`define MBF_FC_IDENT 8'h2b
`define MBF_EXC_FLAG 8'h80
`define MBF_EXC_ILLFN 8'h01
`define MBF_CRC_INIT 16'hffff
`define MBF_CRC_POLY 16'ha001
`endif

/* mbf_rtu_slave.v */
// Behaviour
// - act as serial slave, answer master queries in the selected variant
// - baud rate settable from 9600 to 115200, master matches it
// - characters are 8 data bits, 1 stop bit, no parity, no flow control
// - a software mode setting picks the protocol variant
// - generic text output is silenced while either variant is selected
// - function codes 0x03 and 0x2b are supported
// - function codes 0x06 and 0x10 are supported
// - node address 0-250, resets to 1, other nonzero addresses ignored
// - frames to node 0 are always accepted and answered
// - typed variant short register is two bytes
// - typed variant long register is four bytes, one register
// - typed variant float register is four bytes, one register
// - offset variant uses word registers, wide values span two
// - multi-byte values go out most significant byte first, except the CRC, which goes low byte first
// - a valid password such as 3142 precedes most writes
`timescale 1ns/100ps
`include "mbf_map.vh"
`default_nettype none
module mbf_rtu_slave (
	input wire core_clk,
	input wire rst,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire rxPin,
	output reg txPin,
	input wire textValid,
	input wire [7:0] textData,
	output reg textReady
);
	localparam [3:0] RX_IDLE = 4'h1;
	localparam [3:0] RX_START = 4'h2;
	localparam [3:0] RX_DATA = 4'h4;
	localparam [3:0] RX_STOP = 4'h8;
	localparam [3:0] TX_IDLE = 4'h1;
	localparam [3:0] TX_BYTE = 4'h2;
	localparam [3:0] TX_CRCL = 4'h4;
	localparam [3:0] TX_CRCH = 4'h8;
	localparam [31:0] DIV_MAX = `MBF_CLK_HZ / `MBF_BAUD_MIN;
	localparam [31:0] DIV_MIN = `MBF_CLK_HZ / `MBF_BAUD_MAX;

	function [15:0] crc16;
		input [15:0] c;
		input [7:0] d;
		integer i;
		reg [15:0] x;
		begin
			x = c ^ {8'h00, d};
			for (i = 0; i < 8; i = i + 1)
				x = x[0] ? ((x >> 1) ^ `MBF_CRC_POLY) : (x >> 1);
			crc16 = x;
		end
	endfunction

	reg [1:0] mode;
	reg [7:0] nodeAddr;
	reg [14:0] baudDiv;
	reg [15:0] password;
	reg [1:0] regType;
	reg [7:0] rxIdx;
	reg rxS1, rxS2, rxS3, rxLevel;
	reg [3:0] rxState;
	reg [14:0] rxCnt;
	reg [2:0] rxBit;
	reg [7:0] rxShift;
	reg rxStrobe, rxStopOk;
	reg [14:0] gapTick;
	reg [5:0] gapCnt;
	reg [7:0] mem [0:255];
	reg [8:0] rxLen, frameLen;
	reg [15:0] rxCrc;
	reg rxBad, frameReady;
	reg excBusy;
	reg [1:0] excCnt;
	reg [7:0] excAddr, excFn;
	reg [31:0] valShift;
	reg [2:0] valCnt;
	reg [8:0] buf0, buf1;
	reg [1:0] bufCnt;
	reg [3:0] txState;
	reg [8:0] txShift;
	reg [3:0] txBits;
	reg [14:0] txCnt;
	reg txLast;
	reg [15:0] txCrc;
	reg pushValid;
	reg [8:0] pushData;
	reg [31:0] next_readData;

	wire bufInReady = (bufCnt != 2'h2);
	wire busReq = avs_waitrequest && (avs_read || avs_write);
	wire isTxb = avs_address == `MBF_REG_TXB;
	wire isTxv = avs_address == `MBF_REG_TXV;
	// a full buffer holds the bus master off rather than losing a byte
	wire busStall = avs_write && ((isTxb && (!bufInReady || excBusy
		|| valCnt != 3'h0)) || (isTxv && valCnt != 3'h0));
	wire busAcc = busReq && !busStall;
	wire busWr = busAcc && avs_write;
	wire relPulse = busWr && avs_address == `MBF_REG_CTRL
		&& avs_writedata[`MBF_CTRL_REL];
	wire pushGo = pushValid && bufInReady;
	wire txIdle = txState == TX_IDLE;
	wire popBuf = txIdle && mode != `MBF_MODE_OFF && bufCnt != 2'h0;
	wire textTake = textValid && textReady && mode == `MBF_MODE_OFF
		&& txIdle;
	wire txTick = !txIdle && txCnt == baudDiv - 15'h1;
	wire txDone = txTick && txBits == 4'h0;
	wire txLoad = (txIdle && (popBuf || textTake))
		|| (txDone && ((txState == TX_BYTE && txLast)
		|| txState == TX_CRCL));
	wire [7:0] txLoadByte = txIdle ? (popBuf ? buf0[7:0] : textData)
		: (txState == TX_BYTE ? txCrc[7:0] : txCrc[15:8]);
	wire rxTick = rxCnt == baudDiv - 15'h1;
	// a spoiled frame with no stored byte must still clear its error
	wire frameEnd = rxState == RX_IDLE && gapTick == baudDiv - 15'h1
		&& gapCnt == `MBF_GAP_BITS - 6'h01
		&& (rxLen != 9'h000 || rxBad);
	wire storeByte = rxStrobe && mode != `MBF_MODE_OFF && rxStopOk
		&& !frameReady && !rxLen[8];
	wire addrOk = mem[0] == nodeAddr || mem[0] == 8'h00;
	wire frameOk = !rxBad && rxCrc == 16'h0000 && rxLen > 9'h003
		&& addrOk;
	wire fnOk = mem[1] == `MBF_FC_READ || mem[1] == `MBF_FC_IDENT
		|| mem[1] == `MBF_FC_WR1 || mem[1] == `MBF_FC_WRN;
	wire [15:0] startField = {mem[2], mem[3]};
	wire [15:0] quantity = {mem[4], mem[5]};
	wire [16:0] listed = (mode == `MBF_MODE_WORD)
		? {1'b0, startField} + `MBF_LIST_BASE : {1'b0, startField};
	wire [17:0] sizeBytes = (mode == `MBF_MODE_TYPED
		&& regType != `MBF_TYPE_SHORT)
		? {quantity, 2'b00} : {1'b0, quantity, 1'b0};
	wire unlocked = password == `MBF_PASS_USER;
	wire txBusy = !txIdle || bufCnt != 2'h0 || excBusy
		|| valCnt != 3'h0;

	// exception bytes first, then queued value bytes, then bus writes
	always @*
	begin
		pushValid = 1'b0;
		pushData = 9'h000;
		if (excBusy)
		begin
			pushValid = 1'b1;
			case (excCnt)
				2'h0: pushData = {1'b0, excAddr};
				2'h1: pushData = {1'b0, excFn | `MBF_EXC_FLAG};
				default: pushData = {1'b1, `MBF_EXC_ILLFN};
			endcase
		end
		else if (valCnt != 3'h0)
		begin
			pushValid = 1'b1;
			pushData = {1'b0, valShift[31:24]};
		end
		else if (busWr && isTxb)
		begin
			pushValid = 1'b1;
			pushData = avs_writedata[8:0];
		end
	end

	always @*
	begin
		case (avs_address)
			`MBF_REG_CTRL: next_readData = {30'h0, mode};
			`MBF_REG_STAT: next_readData = {15'h0, frameLen, 5'h0,
				txBusy, unlocked, frameReady};
			`MBF_REG_NODE: next_readData = {24'h0, nodeAddr};
			`MBF_REG_BAUD: next_readData = {17'h0, baudDiv};
			`MBF_REG_RXB: next_readData = {24'h0, mem[rxIdx]};
			`MBF_REG_TYPE: next_readData = {30'h0, regType};
			`MBF_REG_PASS: next_readData = {16'h0, password};
			`MBF_REG_LIST: next_readData = {15'h0, listed};
			`MBF_REG_SIZE: next_readData = {14'h0, sizeBytes};
			default: next_readData = 32'h0;
		endcase
	end

	always @(posedge core_clk or posedge rst)
		if (rst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
			mode <= `MBF_MODE_OFF;
			nodeAddr <= `MBF_NODE_RST;
			baudDiv <= DIV_MAX[14:0];
			password <= 16'h0;
			regType <= `MBF_TYPE_SHORT;
			rxIdx <= 8'h0;
		end
		else
		begin
			avs_waitrequest <= !busAcc;
			if (busAcc && avs_read)
				avs_readdata <= next_readData;
			if (busWr)
				case (avs_address)
					`MBF_REG_CTRL: mode <= avs_writedata[1:0];
					`MBF_REG_NODE:
						if (avs_writedata[7:0] <= `MBF_NODE_MAX)
							nodeAddr <= avs_writedata[7:0];
					`MBF_REG_BAUD:
						if (avs_writedata[14:0] >= DIV_MIN[14:0]
							&& avs_writedata[14:0] <= DIV_MAX[14:0]
							&& avs_writedata[31:15] == 17'h0)
							baudDiv <= avs_writedata[14:0];
					`MBF_REG_RXB: rxIdx <= avs_writedata[7:0];
					`MBF_REG_TYPE: regType <= avs_writedata[1:0];
					`MBF_REG_PASS: password <= avs_writedata[15:0];
					default: ;
				endcase
		end

	always @(posedge core_clk or posedge rst)
		if (rst)
		begin
			rxS1 <= 1'b1;
			rxS2 <= 1'b1;
			rxS3 <= 1'b1;
			rxLevel <= 1'b1;
			rxState <= RX_IDLE;
			rxCnt <= 15'h0;
			rxBit <= 3'h0;
			rxShift <= 8'h0;
			rxStrobe <= 1'b0;
			rxStopOk <= 1'b0;
		end
		else
		begin
			rxS1 <= rxPin;
			rxS2 <= rxS1;
			rxS3 <= rxS2;
			if (rxS2 == rxS3)
				rxLevel <= rxS3;
			rxStrobe <= 1'b0;
			rxCnt <= rxCnt + 15'h1;
			case (rxState)
				RX_IDLE:
				begin
					rxCnt <= 15'h0;
					if (!rxLevel)
						rxState <= RX_START;
				end
				RX_START:
					if (rxCnt == (baudDiv >> 1))
					begin
						rxCnt <= 15'h0;
						rxBit <= 3'h0;
						rxState <= rxLevel ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (rxTick)
					begin
						rxCnt <= 15'h0;
						rxShift <= {rxLevel, rxShift[7:1]};
						rxBit <= rxBit + 3'h1;
						if (rxBit == 3'h7)
							rxState <= RX_STOP;
					end
				RX_STOP:
					if (rxTick)
					begin
						rxStrobe <= 1'b1;
						rxStopOk <= rxLevel;
						rxState <= RX_IDLE;
					end
				default: rxState <= RX_IDLE;
			endcase
		end

	always @(posedge core_clk or posedge rst)
		if (rst)
		begin
			gapTick <= 15'h0;
			gapCnt <= 6'h0;
		end
		else if (rxState != RX_IDLE)
		begin
			gapTick <= 15'h0;
			gapCnt <= 6'h0;
		end
		else if (gapCnt != `MBF_GAP_BITS)
		begin
			gapTick <= gapTick + 15'h1;
			if (gapTick == baudDiv - 15'h1)
			begin
				gapTick <= 15'h0;
				gapCnt <= gapCnt + 6'h1;
			end
		end

	always @(posedge core_clk)
		if (storeByte)
			mem[rxLen[7:0]] <= rxShift;

	always @(posedge core_clk or posedge rst)
		if (rst)
		begin
			rxLen <= 9'h0;
			rxCrc <= `MBF_CRC_INIT;
			rxBad <= 1'b0;
			frameLen <= 9'h0;
			frameReady <= 1'b0;
			excBusy <= 1'b0;
			excCnt <= 2'h0;
			excAddr <= 8'h0;
			excFn <= 8'h0;
		end
		else
		begin
			if (frameEnd)
			begin
				rxLen <= 9'h0;
				rxCrc <= `MBF_CRC_INIT;
				rxBad <= 1'b0;
			end
			else if (storeByte)
			begin
				rxLen <= rxLen + 9'h1;
				rxCrc <= crc16(rxCrc, rxShift);
			end
			// held frame, overrun or bad stop bit spoils the frame
			else if (rxStrobe && mode != `MBF_MODE_OFF)
				rxBad <= 1'b1;
			if (frameEnd && frameOk && fnOk)
			begin
				frameReady <= 1'b1;
				frameLen <= rxLen;
			end
			else if (relPulse)
				frameReady <= 1'b0;
			if (frameEnd && frameOk && !fnOk)
			begin
				excBusy <= 1'b1;
				excCnt <= 2'h0;
				excAddr <= mem[0];
				excFn <= mem[1];
			end
			else if (excBusy && bufInReady)
			begin
				excCnt <= excCnt + 2'h1;
				if (excCnt == 2'h2)
					excBusy <= 1'b0;
			end
		end

	always @(posedge core_clk or posedge rst)
		if (rst)
		begin
			valShift <= 32'h0;
			valCnt <= 3'h0;
		end
		else if (busWr && isTxv)
		begin
			valCnt <= (regType == `MBF_TYPE_SHORT) ? 3'h2 : 3'h4;
			valShift <= (regType == `MBF_TYPE_SHORT)
				? {avs_writedata[15:0], 16'h0} : avs_writedata;
		end
		else if (!excBusy && valCnt != 3'h0 && bufInReady)
		begin
			valCnt <= valCnt - 3'h1;
			valShift <= {valShift[23:0], 8'h0};
		end

	always @(posedge core_clk or posedge rst)
		if (rst)
		begin
			buf0 <= 9'h0;
			buf1 <= 9'h0;
			bufCnt <= 2'h0;
		end
		else
			case ({pushGo, popBuf})
				2'b10:
				begin
					if (bufCnt == 2'h0)
						buf0 <= pushData;
					else
						buf1 <= pushData;
					bufCnt <= bufCnt + 2'h1;
				end
				2'b01:
				begin
					buf0 <= buf1;
					bufCnt <= bufCnt - 2'h1;
				end
				2'b11:
				begin
					if (bufCnt == 2'h1)
						buf0 <= pushData;
					else
					begin
						buf0 <= buf1;
						buf1 <= pushData;
					end
				end
				default: ;
			endcase

	always @(posedge core_clk or posedge rst)
		if (rst)
		begin
			txState <= TX_IDLE;
			txPin <= 1'b1;
			txShift <= 9'h1ff;
			txBits <= 4'h0;
			txCnt <= 15'h0;
			txLast <= 1'b0;
			txCrc <= `MBF_CRC_INIT;
			textReady <= 1'b0;
		end
		else
		begin
			textReady <= mode != `MBF_MODE_OFF || (txIdle && !txLoad);
			if (txLoad)
			begin
				txPin <= 1'b0;
				txShift <= {1'b1, txLoadByte};
				txBits <= 4'h9;
				txCnt <= 15'h0;
			end
			else if (!txIdle)
			begin
				txCnt <= txTick ? 15'h0 : txCnt + 15'h1;
				if (txTick && txBits != 4'h0)
				begin
					txPin <= txShift[0];
					txShift <= {1'b1, txShift[8:1]};
					txBits <= txBits - 4'h1;
				end
			end
			case (txState)
				TX_IDLE:
					if (popBuf)
					begin
						txCrc <= crc16(txCrc, buf0[7:0]);
						txLast <= buf0[`MBF_TXB_LAST];
						txState <= TX_BYTE;
					end
					else if (textTake)
					begin
						txLast <= 1'b0;
						txState <= TX_BYTE;
					end
				TX_BYTE:
					if (txDone)
						txState <= txLast ? TX_CRCL : TX_IDLE;
				TX_CRCL:
					if (txDone)
						txState <= TX_CRCH;
				TX_CRCH:
					if (txDone)
					begin
						txCrc <= `MBF_CRC_INIT;
						txState <= TX_IDLE;
					end
				default: txState <= TX_IDLE;
			endcase
		end
endmodule // mbf_rtu_slave
`default_nettype wire

/* mbf_rtu_checker_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module mbf_rtu_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic rxPin,
	input wire logic txPin,
	input wire logic textValid,
	input wire logic [7:0] textData,
	input wire logic textReady
);
	logic [1:0] mode;
	logic [7:0] node;
	logic [15:0] pass;
	wire wrDone = avs_write && !avs_waitrequest;
	wire rdDone = avs_read && !avs_waitrequest;
	// shadows move only at the accepting edge
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mode <= 2'h0;
			node <= 8'h01;
			pass <= 16'h0000;
		end
		else if (wrDone)
		begin
			if (avs_address == 4'h0)
				mode <= avs_writedata[1:0];
			if (avs_address == 4'h2 && avs_writedata[7:0] <= 8'hfa)
				node <= avs_writedata[7:0];
			if (avs_address == 4'h8)
				pass <= avs_writedata[15:0];
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	chk_accept_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("waitrequest low with no request");
	chk_quick_answer: assert property (avs_waitrequest && (avs_read || avs_write
		&& avs_address != 4'h5 && avs_address != 4'h6) |=> !avs_waitrequest)
		else $error("request not answered next cycle");
	chk_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without a read");
	chk_node_read: assert property (rdDone && avs_address == 4'h2
		|-> avs_readdata[7:0] == node)
		else $error("node address wrong");
	chk_pass_flag: assert property (rdDone && avs_address == 4'h1
		|-> avs_readdata[1] == (pass == 16'h0c46))
		else $error("unlock flag wrong");
	chk_mode_read: assert property (rdDone && avs_address == 4'h0
		|-> avs_readdata[1:0] == mode)
		else $error("mode readback wrong");
	chk_text_silent: assert property ((mode != 2'h0) [*3] |-> textReady)
		else $error("text source not drained");
endmodule // mbf_rtu_checker
bind mbf_rtu_slave mbf_rtu_checker chk_u (.core_clk(core_clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .rxPin(rxPin), .txPin(txPin),
	.textValid(textValid), .textData(textData), .textReady(textReady));
`default_nettype wire

/* mbf_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mbf_master_model #(parameter int BIT_CLKS = 1736) (
	input wire logic core_clk,
	output logic rxLine,
	input wire logic txLine
);
	initial rxLine = 1'b1;
	function automatic logic [15:0] crc16(input logic [7:0] m[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (m[i])
		begin
			c ^= {8'h00, m[i]};
			repeat (8)
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction
	task automatic sendByte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rxLine <= f[i];
			repeat (BIT_CLKS) @(posedge core_clk);
		end
	endtask
	task automatic sendFrame(input logic [7:0] m[$]);
		logic [15:0] c;
		c = crc16(m);
		m.push_back(c[7:0]);
		m.push_back(c[15:8]);
		foreach (m[i])
			sendByte(m[i]);
	endtask
	// sample mid bit, then wait to the middle of the stop bit
	task automatic getByte(output logic [7:0] b);
		while (txLine !== 1'b0)
			@(posedge core_clk);
		repeat (BIT_CLKS / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CLKS) @(posedge core_clk);
			b[i] = txLine;
		end
		repeat (BIT_CLKS) @(posedge core_clk);
	endtask
endmodule // mbf_master_model
`default_nettype wire

/* mbf_rtu_slave_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module mbf_rtu_slave_tb;
	logic core_clk, rst, avsRead, avsWrite, textValid;
	logic [3:0] avsAddr;
	logic [31:0] avsWdata, rdata;
	logic [7:0] got, exp[$];
	logic [15:0] crc;
	wire [31:0] avsRdata;
	wire waitReq, txLine, textReady, rxLine;
	int mismatches = 0, samplesChecked = 0, cycles = 0;
	mbf_rtu_slave dut_u (.core_clk(core_clk), .rst(rst), .avs_address(avsAddr),
		.avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata),
		.avs_readdata(avsRdata), .avs_waitrequest(waitReq), .rxPin(rxLine),
		.txPin(txLine), .textValid(textValid), .textData(8'ha5),
		.textReady(textReady));
	mbf_master_model #(.BIT_CLKS(1736)) master_u (.core_clk(core_clk),
		.rxLine(rxLine), .txLine(txLine));
	task automatic endSim();
		$display("mismatches %0d checked %0d", mismatches, samplesChecked);
		if (mismatches == 0 && samplesChecked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, expv);
		samplesChecked++;
		if (seen !== expv)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, expv, seen);
		end
	endtask
	// the wait ends only on waitrequest low or the run timeout
	task automatic busCycle(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		avsRead <= !w;
		avsWrite <= w;
		avsAddr <= a;
		avsWdata <= d;
		do
			@(posedge core_clk);
		while (waitReq !== 1'b0);
		rdata = avsRdata;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask
	task automatic rdChk(input string what, input logic [3:0] a,
		input logic [31:0] mask, expv);
		busCycle(1'b0, a, 32'h0);
		check(what, rdata & mask, expv);
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 500000)
		begin
			mismatches++;
			endSim();
		end
	end
	initial
	begin
		rst = 1'b1;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsAddr = 4'h0;
		avsWdata = 32'h0;
		textValid = 1'b0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rdChk("node", 4'h2, 32'hff, 32'h01);
		busCycle(1'b1, 4'h2, 32'hfb);
		rdChk("node", 4'h2, 32'hff, 32'h01);
		busCycle(1'b1, 4'h2, 32'hfa);
		rdChk("node", 4'h2, 32'hff, 32'hfa);
		rdChk("unlock", 4'h1, 32'h2, 32'h0);
		busCycle(1'b1, 4'h8, 32'h0c46);
		rdChk("unlock", 4'h1, 32'h2, 32'h2);
		busCycle(1'b1, 4'h3, 32'h6c7);
		rdChk("baud", 4'h3, 32'h7fff, 32'h5161);
		busCycle(1'b1, 4'h3, 32'h6c8);
		rdChk("baud", 4'h3, 32'h7fff, 32'h6c8);
		rdChk("mode", 4'h0, 32'h3, 32'h0);
		// mode 0 passes text bytes out raw
		textValid <= 1'b1;
		master_u.getByte(got);
		textValid <= 1'b0;
		check("text byte", got, 32'ha5);
		busCycle(1'b1, 4'h0, 32'h1);
		textValid <= 1'b1;
		// long enough to see a wrongly started text byte
		repeat (2000) @(posedge core_clk);
		check("tx idle", txLine, 1'b1);
		check("text ready", textReady, 1'b1);
		// start field is 47001 less 40001; node 0 reaches any unit
		master_u.sendFrame('{8'h00, 8'h03, 8'h1b, 8'h58, 8'h00, 8'h02});
		do
			busCycle(1'b0, 4'h1, 32'h0);
		while (rdata[0] !== 1'b1);
		check("length", rdata[16:8], 32'h8);
		rdChk("listed", 4'h9, 32'h1ffff, 32'h0b799);
		rdChk("size", 4'ha, 32'hffff, 32'h4);
		busCycle(1'b1, 4'h4, 32'h1);
		rdChk("code", 4'h4, 32'hff, 32'h03);
		// held frame reread under the typed variant
		busCycle(1'b1, 4'h0, 32'h2);
		rdChk("listed", 4'h9, 32'h1ffff, 32'h01b58);
		rdChk("size", 4'ha, 32'hffff, 32'h4);
		busCycle(1'b1, 4'h7, 32'h2);
		rdChk("size", 4'ha, 32'hffff, 32'h8);
		busCycle(1'b1, 4'h7, 32'h1);
		rdChk("size", 4'ha, 32'hffff, 32'h8);
		busCycle(1'b1, 4'h0, 32'h101);
		rdChk("held", 4'h1, 32'h1, 32'h0);
		rdChk("size", 4'ha, 32'hffff, 32'h4);
		exp = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
		crc = master_u.crc16(exp);
		exp.push_back(crc[7:0]);
		exp.push_back(crc[15:8]);
		fork
			begin
				busCycle(1'b1, 4'h6, 32'h11223344);
				busCycle(1'b1, 4'h5, 32'h155);
			end
			foreach (exp[i])
			begin
				master_u.getByte(got);
				check("tx byte", got, exp[i]);
			end
		join
		// crc high stop bit still going out
		rdChk("tx busy", 4'h1, 32'h4, 32'h4);
		repeat (1736) @(posedge core_clk);
		rdChk("tx busy", 4'h1, 32'h4, 32'h0);
		endSim();
	end
endmodule // mbf_rtu_slave_tb
`default_nettype wire
